// ==== design/chan_cfg_bank.v ====
// eight channel configuration registers and the channel sequencer
`include "chan_cfg_defs.vh"
module chan_cfg_bank #(
    parameter NUM_CH = 8,
    parameter CONV_LEN = 256
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register access from the serial port decoder
    input wire wr_en,
    input wire rd_en,
    input wire [5:0] addr,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    // conversion side
    output reg conv_active,
    output reg [2:0] conv_channel,
    output reg [2:0] conv_setup,
    output reg [4:0] conv_pos_route,
    output reg [4:0] conv_neg_route,
    output reg conv_route_valid,
    output reg conv_start
);
    localparam ST_IDLE = 2'b01;
    localparam ST_CONV = 2'b10;

    reg [15:0] ch_reg [0:NUM_CH-1];
    reg [1:0] state_reg;
    reg [2:0] cur_reg;
    reg [15:0] cnt_reg;
    reg [2:0] nxt_ch;
    reg nxt_found;
    wire hit;
    wire [2:0] idx;
    wire pos_ok;
    wire neg_ok;
    wire [4:0] pos_rt;
    wire [4:0] neg_rt;
    integer i;
    integer j;
    integer k;

    assign hit = (addr >= `CH0_ADDR) && (addr <= `CH7_ADDR);
    assign idx = addr[2:0];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch_reg[0] <= `CH0_RESET;
            for (i = 1; i < NUM_CH; i = i + 1) begin
                ch_reg[i] <= `CHN_RESET;
            end
        end else if (wr_en && hit) begin
            ch_reg[idx] <= wr_data & `WR_MASK;
        end
    end

    // read returns stored word; unmapped addresses read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= hit ? ch_reg[idx] : 16'h0000;
            end
        end
    end

    // search order notes:
    // the loop runs from the farthest candidate down to the nearest,
    // so the last hit kept is the first enabled channel after cur_reg
    // a lone enabled channel is found again at distance NUM_CH,
    // which keeps a single channel converting back to back
    // own loop variables: sharing one integer with the clocked reset
    // loop would give it two drivers
    // next enabled channel search
    always @* begin
        k = 0;
        nxt_ch = cur_reg;
        nxt_found = 1'b0;
        for (j = NUM_CH; j >= 1; j = j - 1) begin
            k = (cur_reg + j) % NUM_CH;
            if (ch_reg[k][`EN_BIT]) begin
                nxt_ch = k[2:0];
                nxt_found = 1'b1;
            end
        end
    end

    sel_decode u_pos (
        .code(ch_reg[nxt_ch][`POS_HI:`POS_LO]),
        .valid(pos_ok),
        .route(pos_rt)
    );
    sel_decode u_neg (
        .code(ch_reg[nxt_ch][`NEG_HI:`NEG_LO]),
        .valid(neg_ok),
        .route(neg_rt)
    );

    // sequencer timing:
    // the start edge loads the counter with CONV_LEN, the conversion
    // then runs CONV_LEN + 1 cycles and one idle cycle rescans, so
    // starts come every CONV_LEN + 2 cycles
    // disabling every channel lets the running conversion finish,
    // then conv_active drops in the idle state
    // limitation: a channel enabled during a conversion waits for
    // the rescan, it never cuts the running one short
    // sequencer: settings latched at conversion start so host writes
    // mid-conversion only take effect on the next pass
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cur_reg <= 3'h7;
            cnt_reg <= 16'h0000;
            conv_active <= 1'b0;
            conv_channel <= 3'h0;
            conv_setup <= 3'h0;
            conv_pos_route <= 5'h00;
            conv_neg_route <= 5'h01;
            conv_route_valid <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (nxt_found) begin
                        state_reg <= ST_CONV;
                        cur_reg <= nxt_ch;
                        cnt_reg <= CONV_LEN[15:0];
                        conv_active <= 1'b1;
                        conv_start <= 1'b1;
                        conv_channel <= nxt_ch;
                        conv_setup <= ch_reg[nxt_ch][`SETUP_HI:`SETUP_LO];
                        conv_pos_route <= pos_rt;
                        conv_neg_route <= neg_rt;
                        conv_route_valid <= pos_ok && neg_ok;
                    end else begin
                        conv_active <= 1'b0;
                    end
                end
                ST_CONV: begin
                    if (cnt_reg == 16'h0000) begin
                        state_reg <= ST_IDLE; // rescans for the next channel
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== design/chan_cfg_defs.vh ====
// constants for the channel configuration register bank
`ifndef CHAN_CFG_DEFS_VH
`define CHAN_CFG_DEFS_VH
`define CH_ADDR_W 6
`define CH0_ADDR 6'h10
`define CH7_ADDR 6'h17
`define CH0_RESET 16'h8001
`define CHN_RESET 16'h0001
`define EN_BIT 15
`define SETUP_HI 14
`define SETUP_LO 12
`define RSV_HI 11
`define RSV_LO 10
`define POS_HI 9
`define POS_LO 5
`define NEG_HI 4
`define NEG_LO 0
`define WR_MASK 16'hf3ff
`define SEL_AIN_MAX 5'h08
`define SEL_MON_P 5'h13
`define SEL_REF_N 5'h16
// conversion length in clk_sys cycles while one channel is held
`define CONV_CYCLES 16'h0100
`endif

// ==== design/sel_decode.v ====
// decodes one input selector code into a routing index and validity
`include "chan_cfg_defs.vh"
module sel_decode (
    // selector code
    input wire [4:0] code,
    // decoded route
    output reg valid,
    output reg [4:0] route
);
    // codes outside the map are flagged reserved and routed to nothing
    always @* begin
        route = code;
        valid = (code <= `SEL_AIN_MAX) || ((code >= `SEL_MON_P) && (code <= `SEL_REF_N));
        if (!valid) begin
            route = 5'h1f;
        end
    end
endmodule

// ==== verif/chan_cfg_bank_assertions.sv ====
// port assertions for the channel bank
module chan_cfg_checker (
    input wire clk_sys, rst_n, wr_en, rd_en, rd_valid, conv_active, conv_start,
    input wire [5:0] addr,
    input wire [15:0] wr_data, rd_data,
    input wire [2:0] conv_setup
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // host write of channel 0, read two edges later
    sequence wr_rd0;
        wr_en && addr == 6'h10 ##2 rd_en && addr == 6'h10;
    endsequence
    rd_ack_a: assert property (rd_en |=> rd_valid) else $error("no read valid");
    rd_once_a: assert property (!rd_en |=> !rd_valid) else $error("stray valid");
    ch0_store_a: assert property (wr_rd0 |=> rd_data == ($past(wr_data, 3) & 16'hf3ff))
        else $error("ch0 data");
    rsv_zero_a: assert property (rd_valid |-> rd_data[11:10] == 2'h0) else $error("rsv");
    unmapped_a: assert property (rd_en && (addr < 6'h10 || addr > 6'h17) |=> rd_data == 16'h0)
        else $error("unmapped");
    start_gap_a: assert property (conv_start |=> !conv_start [*5]) else $error("gap");
    start_act_a: assert property (conv_start |-> conv_active) else $error("idle");
    setup_hold_a: assert property (!conv_start |-> $stable(conv_setup)) else $error("setup");
endmodule
bind chan_cfg_bank chan_cfg_checker chk (.*);

// ==== verif/chan_cfg_bank_tb.sv ====
// bench for the channel configuration bank
module chan_cfg_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, rd_valid, conv_active, conv_start, conv_route_valid, wr_en, rd_en;
    logic [5:0] addr;
    logic [15:0] wr_data, rd_data, v;
    logic [2:0] conv_channel, conv_setup;
    logic [4:0] conv_pos_route, conv_neg_route;
    int err_count = 0, check_count = 0;
    always #2.5 clk_sys = ~clk_sys;
    chan_cfg_bank #(.CONV_LEN(4)) dut (.*);
    host_model host (.*);
    task chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // bounded wait for a start on one channel
    task wait_ch(input logic [2:0] c);
        for (int i = 0; i < 40 && !(conv_start === 1'b1 && conv_channel === c); i++)
            @(posedge clk_sys) #1;
        chk("start", {conv_start, conv_channel}, {1'b1, c});
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            host.rd(6'h10 + i[5:0], v);
            chk("reset", v, i == 0 ? 16'h8001 : 16'h0001);
        end
        host.rd(6'h0f, v);
        chk("unmapped", v, 16'h0000);
        // reserved bits written high must read low
        host.wr(6'h11, 16'hfeb6);
        host.rd(6'h11, v);
        chk("ch1", v, 16'hf2b6);
        wait_ch(3'h1);
        chk("setup", conv_setup, 3'h7);
        chk("route", {conv_pos_route, conv_neg_route}, 10'h2b6);
        wait_ch(3'h0);
        chk("setup0", conv_setup, 3'h0);
        // undefined selector code is flagged
        host.wr(6'h12, 16'h8121);
        wait_ch(3'h2);
        chk("valid", conv_route_valid, 1'b0);
        // monitor code 5'h13 on the positive selector is routed as valid
        host.wr(6'h13, 16'h8260);
        wait_ch(3'h3);
        chk("monitor", {conv_route_valid, conv_pos_route, conv_neg_route}, 11'h660);
        for (int i = 0; i < 4; i++)
            host.wr(6'h13 - i[5:0], 16'h0001);
        host.rd(6'h10, v);
        chk("ch0", v, 16'h0001);
        repeat (20) @(posedge clk_sys);
        #1 chk("active", conv_active, 1'b0);
        end_of_test;
    end
    initial begin
        #20000;
        err_count++;
        end_of_test;
    end
endmodule

// ==== verif/host_model.sv ====
// host side of the register strobes
module host_model (
    input wire clk_sys,
    input wire [15:0] rd_data,
    output reg wr_en, rd_en,
    output reg [5:0] addr,
    output reg [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en, rd_en, addr, wr_data} = '0;
    // released data is inverted so stale values never look valid
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {wr_en, addr, wr_data} <= {1'b1, a, d};
        @(posedge clk_sys);
        {wr_en, wr_data} <= {1'b0, ~d};
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        {rd_en, addr} <= {1'b1, a};
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(posedge clk_sys);
        d = rd_data;
    endtask
endmodule
